// [design/uhi_uart_host.sv]
// uart host interface: serial register access for an external host controller
// assumes the register file sits outside and answers a read strobe one cycle later
//
// Notes on behaviour
// - after reset the link runs at 115.2 kbit/s until the rate register is rewritten.
// - with exponent zero the bit rate is 27.12 MHz over divisor plus one.
// - with nonzero exponent it is 27.12 MHz over divisor plus 33, over two to exponent less one.
// - each character is a low start bit, eight data bits and a high stop bit.
// - bytes travel least significant bit first with no parity.
// - a read is one mode-and-address byte answered by one character of register data.
// - a write is address byte then data byte, and the address byte is echoed back.
// - the data byte is accepted whatever the echo's progress.
// - bit 0 of the first byte is 1 for read, 0 for write, bits 7 to 1 the address.
// - the uart is selected when both select pins are low after reset; rx is pin 0, tx pin 2.
module uhi_uart_host
	import uhi_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// host pins
	input wire logic host_pin_0,
	output logic host_pin_2,
	input wire logic host_pin_3,
	input wire logic host_select_0,
	input wire logic host_select_1,
	// register file access
	output logic [6:0] reg_addr,
	output logic reg_wr_strobe,
	output logic [7:0] reg_wr_data,
	output logic reg_rd_strobe,
	input wire logic [7:0] reg_rd_data,
	// status
	output logic uart_selected,
	output logic [7:0] serial_rate_register,
	output logic rx_overrun,
	output logic rx_frame_error
);
	// pin synchronisers: three stages, level taken when stages two and three agree
	logic [2:0] rx_sync;
	logic [2:0] trig_sync;
	logic [2:0] sel0_sync;
	logic [2:0] sel1_sync;
	logic rx_level;
	logic trig_level;
	logic sel0_level;
	logic sel1_level;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sync <= 3'h7;
			trig_sync <= 3'h0;
			sel0_sync <= 3'h7;
			sel1_sync <= 3'h7;
			rx_level <= 1'b1;
			trig_level <= 1'b0;
			sel0_level <= 1'b1;
			sel1_level <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], host_pin_0};
			trig_sync <= {trig_sync[1:0], host_pin_3};
			sel0_sync <= {sel0_sync[1:0], host_select_0};
			sel1_sync <= {sel1_sync[1:0], host_select_1};
			if (rx_sync[1] == rx_sync[2]) rx_level <= rx_sync[2];
			if (trig_sync[1] == trig_sync[2]) trig_level <= trig_sync[2];
			if (sel0_sync[1] == sel0_sync[2]) sel0_level <= sel0_sync[2];
			if (sel1_sync[1] == sel1_sync[2]) sel1_level <= sel1_sync[2];
		end
	end

	// select pins caught once, after the synchronisers have settled
	logic [2:0] settle;
	logic sel_done;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle <= 3'h0;
			sel_done <= 1'b0;
			uart_selected <= 1'b0;
		end else if (!sel_done) begin
			if (settle == SEL_SETTLE) begin
				sel_done <= 1'b1;
				uart_selected <= !sel0_level && !sel1_level;
			end else begin
				settle <= settle + 3'h1;
			end
		end
	end

	// bit period as a fractional count: reference ticks scaled to core cycles
	logic [31:0] bit_limit;
	assign bit_limit = {19'h0, uhi_bit_ticks(serial_rate_register)} * CORE_CLK_KHZ;

	// transmitter
	logic tx_busy;
	logic tx_start;
	logic [7:0] tx_byte;
	logic [8:0] tx_shift;
	logic [3:0] tx_count;
	logic [31:0] tx_acc;
	logic [31:0] tx_sum;
	logic tx_hit;

	assign tx_sum = tx_acc + SYS_REF_KHZ;
	assign tx_hit = tx_sum >= bit_limit;

	// one bit per period; line idles high
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy <= 1'b0;
			tx_shift <= 9'h1ff;
			tx_count <= 4'h0;
			tx_acc <= 32'h0;
			host_pin_2 <= 1'b1;
		end else if (tx_start) begin
			tx_busy <= 1'b1;
			tx_shift <= {1'b1, tx_byte};
			tx_count <= FRAME_BITS;
			tx_acc <= 32'h0;
			host_pin_2 <= 1'b0;
		end else if (tx_busy) begin
			tx_acc <= tx_hit ? tx_sum - bit_limit : tx_sum;
			if (tx_hit) begin
				if (tx_count == 4'h1) begin
					tx_busy <= 1'b0;
				end else begin
					host_pin_2 <= tx_shift[0];
					tx_shift <= {1'b1, tx_shift[8:1]};
					tx_count <= tx_count - 4'h1;
				end
			end
		end
	end

	// receiver: samples at mid-bit, counting from the start edge
	logic rx_busy;
	logic rx_prev;
	logic [3:0] rx_index;
	logic [7:0] rx_shift;
	logic [31:0] rx_acc;
	logic [31:0] rx_sum;
	logic rx_hit;
	logic rx_push;
	logic [7:0] rx_word;
	uhi_stream_if #(.WIDTH(FIFO_WIDTH)) rx_stream ();

	assign rx_sum = rx_acc + SYS_REF_KHZ;
	assign rx_hit = rx_sum >= bit_limit;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_busy <= 1'b0;
			rx_prev <= 1'b1;
			rx_index <= 4'h0;
			rx_shift <= 8'h00;
			rx_acc <= 32'h0;
			rx_push <= 1'b0;
			rx_word <= 8'h00;
			rx_frame_error <= 1'b0;
		end else begin
			rx_prev <= rx_level;
			rx_push <= 1'b0;
			rx_frame_error <= 1'b0;
			if (!rx_busy) begin
				// a falling edge realigns the half-period phase
				if (uart_selected && rx_prev && !rx_level) begin
					rx_busy <= 1'b1;
					rx_index <= 4'h0;
					rx_acc <= bit_limit >> 1;
				end
			end else begin
				rx_acc <= rx_hit ? rx_sum - bit_limit : rx_sum;
				if (rx_hit) begin
					rx_index <= rx_index + 4'h1;
					if (rx_index == 4'h0) begin
						rx_busy <= !rx_level; // glitch, not a start bit
					end else if (rx_index == STOP_INDEX) begin
						rx_busy <= 1'b0;
						rx_push <= rx_level;
						rx_word <= rx_shift;
						rx_frame_error <= !rx_level;
					end else begin
						rx_shift <= {rx_level, rx_shift[7:1]};
					end
				end
			end
		end
	end

	// the serial line cannot be held off, so a full buffer loses the byte
	assign rx_stream.wr_valid = rx_push;
	assign rx_stream.wr_data = rx_word;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_overrun <= 1'b0;
		end else begin
			rx_overrun <= rx_push && !rx_stream.wr_ready;
		end
	end

	uhi_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.port(rx_stream)
	);

	// command sequencer
	uhi_state_type state;
	logic [7:0] head;
	logic take;
	logic is_rate;

	// a new command waits for the transmitter so its answer can go out
	assign rx_stream.rd_ready = (state == ST_IDLE && !tx_busy && !tx_start)
		|| state == ST_WRITE_DATA;
	assign take = rx_stream.rd_valid && rx_stream.rd_ready;
	assign head = rx_stream.rd_data;
	assign is_rate = (reg_addr == RATE_REG_ADDR);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			reg_addr <= 7'h00;
			reg_wr_strobe <= 1'b0;
			reg_wr_data <= 8'h00;
			reg_rd_strobe <= 1'b0;
			tx_start <= 1'b0;
			tx_byte <= 8'h00;
			serial_rate_register <= RATE_RESET;
		end else begin
			reg_wr_strobe <= 1'b0;
			reg_rd_strobe <= 1'b0;
			tx_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (take) begin
						reg_addr <= head[ADDR_MSB:ADDR_LSB];
						if (head[MODE_BIT]) begin
							state <= ST_READ_WAIT;
						end else begin
							tx_start <= 1'b1;
							tx_byte <= head;
							state <= ST_WRITE_DATA;
						end
					end
				end
				ST_READ_WAIT: begin
					if (trig_level) begin
						reg_rd_strobe <= !is_rate;
						state <= ST_READ_FETCH;
					end
				end
				ST_READ_FETCH: begin
					state <= ST_READ_SEND;
				end
				ST_READ_SEND: begin
					tx_start <= 1'b1;
					tx_byte <= is_rate ? serial_rate_register : reg_rd_data;
					state <= ST_IDLE;
				end
				ST_WRITE_DATA: begin
					// data may arrive while the echo is still on the line
					if (take) begin
						if (is_rate) begin
							serial_rate_register <= head;
						end else begin
							reg_wr_strobe <= 1'b1;
						end
						reg_wr_data <= head;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// [common/uhi_pkg.sv]
// uart host interface: shared constants, types and the bit-period function
// assumes a single core clock of 25 MHz; rates are defined against 27.12 MHz
package uhi_pkg;

	// clocks, in kHz; the bit period is set in ticks of the reference clock
	localparam logic [31:0] CORE_CLK_KHZ = 32'h0000_61a8; // 25000
	localparam logic [31:0] SYS_REF_KHZ = 32'h0000_69f0; // 27120

	// serial rate register layout and reset value (115.2 kbit/s)
	localparam logic [7:0] RATE_RESET = 8'h7a;
	localparam int RATE_EXP_MSB = 7;
	localparam int RATE_EXP_LSB = 5;
	localparam int RATE_DIV_MSB = 4;
	localparam int RATE_DIV_LSB = 0;
	localparam logic [12:0] DIV_ADD_LOW = 13'h0001;
	localparam logic [12:0] DIV_ADD_HIGH = 13'h0021;

	// internal address of the serial rate register
	localparam logic [6:0] RATE_REG_ADDR = 7'h3b;

	// mode-and-address byte layout
	localparam int MODE_BIT = 0;
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 1;

	// character framing: start, eight data, stop
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam logic [3:0] STOP_INDEX = 4'h9;

	// receive buffer
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// cycles after reset release before the interface-select pins are caught
	localparam logic [2:0] SEL_SETTLE = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ_WAIT = 3'b001,
		ST_READ_FETCH = 3'b010,
		ST_READ_SEND = 3'b011,
		ST_WRITE_DATA = 3'b100
	} uhi_state_type;

	// bit period in reference-clock ticks
	function automatic logic [12:0] uhi_bit_ticks(input logic [7:0] rate);
		logic [2:0] e;
		logic [12:0] d;
		e = rate[RATE_EXP_MSB:RATE_EXP_LSB];
		d = {8'h00, rate[RATE_DIV_MSB:RATE_DIV_LSB]};
		if (e == 3'h0) begin
			return d + DIV_ADD_LOW;
		end
		return (d + DIV_ADD_HIGH) << (e - 3'h1);
	endfunction

endpackage

// [common/uhi_stream_if.sv]
// uart host interface: valid/ready stream carrier between top and buffer
// assumes both ends run on the same clock
interface uhi_stream_if #(parameter int WIDTH = 8);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport buffer (
		input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data
	);
	modport user (
		output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data
	);
endinterface

// [design/uhi_fifo.sv]
// uart host interface: small first-in first-out buffer with registered read data
// assumes one clock and an asynchronous active-low reset
module uhi_fifo
	import uhi_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// stream both sides
	uhi_stream_if.buffer port
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] mem_count;
	logic push;
	logic take;

	// output stage refills whenever it is empty or being drained
	assign port.wr_ready = (mem_count != FULL_COUNT);
	assign push = port.wr_valid && port.wr_ready;
	assign take = (mem_count != '0) && (!port.rd_valid || port.rd_ready);

	// storage array, no reset needed on data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= port.wr_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			mem_count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
			if (take) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			end
			mem_count <= mem_count + (PW + 1)'(push) - (PW + 1)'(take);
		end
	end

	// registered read word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port.rd_valid <= 1'b0;
			port.rd_data <= '0;
		end else if (take) begin
			port.rd_valid <= 1'b1;
			port.rd_data <= mem[rd_ptr];
		end else if (port.rd_ready) begin
			port.rd_valid <= 1'b0;
		end
	end
endmodule

// [tb/uhi_uart_host_sva.sv]
// checker for the uart host block, sees only its ports
// assumes one clock domain and an active-low reset
module uhi_uart_host_sva
	import uhi_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// host pins
	input wire logic host_pin_0,
	input wire logic host_pin_2,
	input wire logic host_pin_3,
	input wire logic host_select_0,
	input wire logic host_select_1,
	// register file
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr_strobe,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_strobe,
	input wire logic [7:0] reg_rd_data,
	// status
	input wire logic uart_selected,
	input wire logic [7:0] serial_rate_register,
	input wire logic rx_overrun,
	input wire logic rx_frame_error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// the start bits at the rates used here span far more than eight cycles; the fastest rate, 0x00, gives a one-cycle start bit
	sequence s_tx_fall;
		$fell(host_pin_2);
	endsequence
	sequence s_start_low;
		!host_pin_2 [*8];
	endsequence
	property p_start_len;
		s_tx_fall |-> s_start_low;
	endproperty
	property p_rd_answer;
		reg_rd_strobe |-> ##[1:5] s_tx_fall;
	endproperty
	property p_rd_trig;
		reg_rd_strobe |-> $past(host_pin_3, 3);
	endproperty
	property p_rd_rate;
		reg_rd_strobe |-> reg_addr != RATE_REG_ADDR;
	endproperty
	property p_wr_rate;
		reg_wr_strobe |-> reg_addr != RATE_REG_ADDR;
	endproperty
	property p_wr_pulse;
		reg_wr_strobe |=> !reg_wr_strobe [*8];
	endproperty
	property p_rate_chg;
		$changed(serial_rate_register) |-> reg_addr == RATE_REG_ADDR;
	endproperty
	property p_sel;
		$rose(uart_selected) |-> !$past(host_select_0, 3) && !$past(host_select_1, 3);
	endproperty
	property p_unsel;
		!uart_selected |-> host_pin_2 && !reg_wr_strobe && !reg_rd_strobe;
	endproperty
	a_start_len: assert property (p_start_len) else $error("start bit short");
	a_rd_answer: assert property (p_rd_answer) else $error("no read reply");
	a_rd_trig: assert property (p_rd_trig) else $error("read without trigger");
	a_rd_rate: assert property (p_rd_rate) else $error("rate read strobed");
	a_wr_rate: assert property (p_wr_rate) else $error("rate write strobed");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe long");
	a_rate_chg: assert property (p_rate_chg) else $error("rate changed");
	a_sel: assert property (p_sel) else $error("bad select");
	a_unsel: assert property (p_unsel) else $error("active unselected");
endmodule

// [tb/uhi_host_model.sv]
// host side uart model: drives the rx pin, decodes the tx pin
// assumes idle-high lines; periods and timeouts in ns
module uhi_host_model (
	// serial lines
	output logic to_dev,
	input wire logic from_dev
);
	timeunit 1ns;
	timeprecision 1ps;
	initial to_dev = 1'b1;
	// one character; a low stop_ok breaks the stop bit on purpose
	task automatic send(input logic [7:0] b, input real per, input logic stop_ok);
		to_dev = 1'b0;
		#(per);
		for (int i = 0; i < 8; i++) begin
			to_dev = b[i];
			#(per);
		end
		to_dev = stop_ok;
		#(per);
		to_dev = 1'b1;
	endtask
	// waits for a start bit, samples mid-bit; ok is the stop level
	task automatic recv(input real per, input real tmo, output logic [7:0] b, output logic ok);
		real t;
		t = 0.0;
		ok = 1'b0;
		b = 8'h00;
		while (from_dev !== 1'b0 && t < tmo) begin
			#10;
			t = t + 10.0;
		end
		if (from_dev === 1'b0) begin
			#(per * 1.5);
			for (int i = 0; i < 8; i++) begin
				b[i] = from_dev;
				#(per);
			end
			ok = from_dev;
		end
	endtask
endmodule

// [tb/uhi_uart_host_tb.sv]
// bench for the uart host block with a host model and register stand-in
// assumes the rate register sits at RATE_REG_ADDR
module uhi_uart_host_tb
	import uhi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// bit periods: 0x7a is 236 ticks, 0x15 is 22 ticks of 27.12 MHz
	localparam real PD = 236.0 * 1000.0 / 27.12;
	localparam real PF = 22.0 * 1000.0 / 27.12;
	localparam int LIMIT = 60000;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic trig = 1'b0;
	logic strap0 = 1'b0;
	logic rx, tx, wr_stb, rd_stb, sel, ovr, ferr, b_ok;
	logic stb_d = 1'b0;
	logic fe_seen = 1'b0;
	logic ov_seen = 1'b0;
	logic [6:0] addr;
	logic [7:0] wr_data, rate, b;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] mem [128];
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n = 0;
	always #20 core_clk = ~core_clk;
	uhi_host_model host (.to_dev(rx), .from_dev(tx));
	uhi_uart_host dut (.core_clk(core_clk), .rst_b(rst_b), .host_pin_0(rx),
		.host_pin_2(tx), .host_pin_3(trig), .host_select_0(strap0), .host_select_1(1'b0),
		.reg_addr(addr), .reg_wr_strobe(wr_stb), .reg_wr_data(wr_data),
		.reg_rd_strobe(rd_stb), .reg_rd_data(rd_data), .uart_selected(sel),
		.serial_rate_register(rate), .rx_overrun(ovr), .rx_frame_error(ferr));
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// register stand-in: data valid only around the strobe, inverted otherwise
	always @(posedge core_clk) begin
		stb_d <= rd_stb;
		rd_data <= (rd_stb || stb_d) ? mem[addr] : ~mem[addr];
		if (wr_stb) mem[addr] <= wr_data;
		if (ferr) fe_seen <= 1'b1;
		if (ovr) ov_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// write; data goes out under the echo unless wait_echo
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input real per, input bit wait_echo);
		logic [7:0] e;
		logic ok;
		fork
			begin
				host.send({a, 1'b0}, per, 1'b1);
				if (!wait_echo) host.send(d, per, 1'b1);
			end
			host.recv(per, 30.0 * per, e, ok);
		join
		if (wait_echo) host.send(d, per, 1'b1);
		chk("echo", e, {a, 1'b0});
		chk("echo stop", {7'h00, ok}, 8'h01);
	endtask
	task automatic rd(input logic [6:0] a, input real per, input logic [7:0] exp);
		logic [7:0] e;
		logic ok;
		fork
			host.send({a, 1'b1}, per, 1'b1);
			host.recv(per, 40.0 * per, e, ok);
		join
		chk("read", e, exp);
		chk("read stop", {7'h00, ok}, 8'h01);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk) rst_b = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("selected", {7'h00, sel}, 8'h01);
		chk("rate reset", rate, RATE_RESET);
		chk("tx idle", {7'h00, tx}, 8'h01);
		trig = 1'b1;
		wr(7'h10, 8'ha5, PD, 1'b0);
		rd(7'h10, PD, 8'ha5);
		$display("test default rate done");
		// a low trigger holds the reply back
		@(negedge core_clk) trig = 1'b0;
		fork
			host.send(8'h21, PD, 1'b1);
			host.recv(PD, 30.0 * PD, b, b_ok);
		join
		chk("held", {7'h00, b_ok}, 8'h00);
		@(negedge core_clk) trig = 1'b1;
		host.recv(PD, 5.0 * PD, b, b_ok);
		chk("released", b, 8'ha5);
		$display("test trigger done");
		// rate change waits for the echo, since it retimes the line at once
		wr(RATE_REG_ADDR, 8'h15, PD, 1'b1);
		@(negedge core_clk);
		chk("rate", rate, 8'h15);
		rd(RATE_REG_ADDR, PF, 8'h15);
		rd(7'h10, PF, 8'ha5);
		host.send(8'h21, PF, 1'b0);
		host.recv(PF, 20.0 * PF, b, b_ok);
		chk("no reply", {7'h00, b_ok}, 8'h00);
		chk("frame err", {7'h00, fe_seen}, 8'h01);
		$display("test rate done");
		// stall with the trigger low until the buffer refuses, then drain
		@(negedge core_clk) trig = 1'b0;
		repeat (FIFO_DEPTH + 4) host.send(8'h21, PF, 1'b1);
		chk("overrun", {7'h00, ov_seen}, 8'h01);
		@(negedge core_clk) trig = 1'b1;
		b_ok = 1'b1;
		while (b_ok) begin
			host.recv(PF, 20.0 * PF, b, b_ok);
			if (b_ok) n++;
			if (b_ok) chk("drain", b, 8'ha5);
		end
		chk("answers", n[7:0], 8'(FIFO_DEPTH + 2));
		$display("test buffer done");
		// one strap high: after a fresh reset the uart must stay deaf
		@(negedge core_clk) rst_b = 1'b0;
		strap0 = 1'b1;
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("unselected", {7'h00, sel}, 8'h00);
		chk("rate again", rate, RATE_RESET);
		host.send(8'h21, PD, 1'b1);
		host.recv(PD, 20.0 * PD, b, b_ok);
		chk("deaf", {7'h00, b_ok}, 8'h00);
		$display("test select done");
		results();
	end
endmodule
bind uhi_uart_host uhi_uart_host_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
	.host_pin_0(host_pin_0), .host_pin_2(host_pin_2), .host_pin_3(host_pin_3),
	.host_select_0(host_select_0), .host_select_1(host_select_1), .reg_addr(reg_addr),
	.reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data),
	.reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
	.uart_selected(uart_selected), .serial_rate_register(serial_rate_register),
	.rx_overrun(rx_overrun), .rx_frame_error(rx_frame_error));
